// *** logic/flash_row_write_sequencer.sv ***
// flash row write sequencer: latches, unlock sequence and row commit over apb
//
// The APB register port and the register offsets were left to the implementer.
module flash_row_write_sequencer (
	input  wire logic                          pclk,        // system clock
	input  wire logic                          presetn,     // async reset, low
	input  wire logic                          psel,        // apb select
	input  wire logic                          penable,     // apb access phase
	input  wire logic                          pwrite,      // apb direction
	input  wire logic [7:0]                    paddr,       // apb byte address
	input  wire logic [31:0]                   pwdata,      // apb write data
	output logic      [31:0]                   prdata,      // apb read data
	output logic                               pready,      // apb ready
	output logic                               pslverr,     // apb error
	output logic                               flash_we,    // row program strobe
	output logic      [flash_row_pkg::ROW_W-1:0]  flash_row,   // row being programmed
	output logic      [flash_row_pkg::LATCH_W-1:0] flash_col,  // word within row
	output logic      [flash_row_pkg::WORD_W-1:0]  flash_wdata, // word to program
	input  wire logic                          flash_ready  // flash accepts word
);
	import flash_row_pkg::*;

	// ==========================================================
	// register storage
	logic [7:0]        addr_low_reg;   // prog_addr_low
	logic [7:0]        addr_high_reg;  // prog_addr_high
	logic [7:0]        data_low_reg;   // prog_data_low
	logic [5:0]        data_high_reg;  // prog_data_high
	logic [7:0]        ctrl_reg;       // flash_control_one
	logic [WORD_W-1:0] latch_reg [LATCH_COUNT]; // write latches
	seq_state_t        state_reg;      // sequencer state
	unlock_state_t     unl_reg;        // unlock progress
	logic [LATCH_W-1:0] col_reg;       // program / blank walk index
	logic [ROW_W-1:0]  row_reg;        // row captured at commit

	// ==========================================================
	// bus decode
	logic acc;        // access phase
	logic wr;         // write takes effect
	logic hit;        // mapped address
	logic unlocked;   // start write completes unlock
	logic busy;       // sequence running
	logic start_done; // load or commit finishing this cycle

	assign acc     = psel && penable;
	assign hit     = (paddr == OFF_ADDR_LOW) || (paddr == OFF_ADDR_HIGH) ||
	                 (paddr == OFF_DATA_LOW) || (paddr == OFF_DATA_HIGH) ||
	                 (paddr == OFF_CTRL) || (paddr == OFF_KEY);
	assign busy    = (state_reg != ST_IDLE);
	assign pready  = 1'b1;               // zero wait state
	assign pslverr = acc && !hit;        // unmapped access answers error
	assign wr      = acc && pwrite && hit;

	// latch word from data pair, high over low
	function automatic logic [WORD_W-1:0] pair_word(input logic [5:0] hi,
		input logic [7:0] lo);
		pair_word = {hi, lo};
	endfunction

	// true on the last column of a row walk
	function automatic logic is_last(input logic [LATCH_W-1:0] col);
		is_last = (col == LATCH_W'(LATCH_COUNT - 1));
	endfunction

	// start write accepted only after both keys; enable set, program space
	assign unlocked = wr && (paddr == OFF_CTRL) && pwdata[BIT_START] &&
	                  (unl_reg == UNL_KEY2) && ctrl_reg[BIT_WRITE_ENABLE_BIT] &&
	                  !ctrl_reg[BIT_CONFIG_SPACE_SELECT] && !busy;

	// a latch load ends in its single cycle, a commit at the end of the
	// blank walk; only then may firmware see the start bit fall
	assign start_done = (state_reg == ST_LOAD && ctrl_reg[BIT_LATCH_ONLY_BIT]) ||
	                    (state_reg == ST_BLANK && is_last(col_reg));

	// ==========================================================
	// unlock tracker: any other access aborts the sequence
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unl_reg <= UNL_NONE;
		end else if (acc) begin
			if (wr && paddr == OFF_KEY && pwdata[7:0] == KEY_FIRST) begin
				unl_reg <= UNL_KEY1;
			end else if (wr && paddr == OFF_KEY && pwdata[7:0] == KEY_SECOND &&
			             unl_reg == UNL_KEY1) begin
				unl_reg <= UNL_KEY2;
			end else begin
				unl_reg <= UNL_NONE;
			end
		end
	end

	// ==========================================================
	// address and data registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_low_reg  <= '0;
			addr_high_reg <= ADDR_HIGH_RST;
			data_low_reg  <= '0;
			data_high_reg <= '0;
		end else if (wr) begin
			unique case (paddr)
				OFF_ADDR_LOW:  addr_low_reg  <= pwdata[7:0];
				OFF_ADDR_HIGH: addr_high_reg <= {1'b1, pwdata[6:0]};
				OFF_DATA_LOW:  data_low_reg  <= pwdata[7:0];
				OFF_DATA_HIGH: data_high_reg <= pwdata[5:0];
				default: ;
			endcase
		end
	end

	// ==========================================================
	// control register; start bit cleared by hardware
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= CTRL_RST;
		end else begin
			if (wr && paddr == OFF_CTRL) begin
				// a write in the finishing cycle must not keep start alive,
				// or a poll would wait forever on an idle sequencer
				ctrl_reg <= {1'b1, pwdata[6:2],
				             unlocked || (ctrl_reg[BIT_START] && !start_done), 1'b0};
			end else if (start_done) begin
				ctrl_reg[BIT_START] <= 1'b0;
			end
		end
	end

	// ==========================================================
	// sequencer: load, program walk, blank walk
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
			col_reg   <= '0;
			row_reg   <= '0;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (unlocked) begin
						state_reg <= ST_LOAD;
						row_reg   <= {addr_high_reg[6:0], addr_low_reg[7:5]};
					end
				end
				ST_LOAD: begin
					col_reg   <= '0;
					state_reg <= ctrl_reg[BIT_LATCH_ONLY_BIT] ? ST_IDLE : ST_PROGRAM;
				end
				ST_PROGRAM: begin
					if (flash_ready) begin
						col_reg <= col_reg + LATCH_W'(1);
						if (is_last(col_reg)) begin
							state_reg <= ST_BLANK;
						end
					end
				end
				ST_BLANK: begin
					col_reg <= col_reg + LATCH_W'(1);
					if (is_last(col_reg)) begin
						state_reg <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// write latches; only index bits reach the latch, so no row spill
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < LATCH_COUNT; i++) begin
				latch_reg[i] <= BLANK_WORD;
			end
		end else if (state_reg == ST_LOAD) begin
			latch_reg[addr_low_reg[LATCH_W-1:0]] <= pair_word(data_high_reg,
				data_low_reg);
		end else if (state_reg == ST_BLANK) begin
			latch_reg[col_reg] <= BLANK_WORD;
		end
	end

	// ==========================================================
	// flash port: programs every latch, no erase ever issued
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flash_we    <= 1'b0;
			flash_row   <= '0;
			flash_col   <= '0;
			flash_wdata <= '0;
		end else begin
			flash_we    <= (state_reg == ST_PROGRAM) && flash_ready;
			flash_row   <= row_reg;
			flash_col   <= col_reg;
			flash_wdata <= latch_reg[col_reg];
		end
	end

	// ==========================================================
	// read mux
	always_comb begin
		prdata = '0;
		if (acc && !pwrite) begin
			unique case (paddr)
				OFF_ADDR_LOW:  prdata = {24'h000000, addr_low_reg};
				OFF_ADDR_HIGH: prdata = {24'h000000, addr_high_reg};
				OFF_DATA_LOW:  prdata = {24'h000000, data_low_reg};
				OFF_DATA_HIGH: prdata = {26'h0000000, data_high_reg};
				OFF_CTRL:      prdata = {24'h000000, ctrl_reg};
				default:       prdata = '0;
			endcase
		end
	end

	// ==========================================================
	// checking aid: words handed to the flash since the last load cycle;
	// one bit wider than a column so that a full row fits
	logic [LATCH_W:0] words_reg; // strobes in this commit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			words_reg <= '0;
		end else if (state_reg == ST_LOAD) begin
			words_reg <= '0; // every operation counts from zero
		end else if (flash_we) begin
			words_reg <= words_reg + (LATCH_W+1)'(1);
		end
	end

	// ==========================================================
	// checking aid: high while every latch holds the blank word
	logic all_blank; // no loaded latch left
	always_comb begin
		all_blank = 1'b1;
		for (int i = 0; i < LATCH_COUNT; i++) begin
			if (latch_reg[i] != BLANK_WORD) begin
				all_blank = 1'b0; // a loaded latch remains
			end
		end
	end

	// ==========================================================
	// assertions
	// the start bit is the only completion signal firmware has, so four
	// checks below guard when it rises, holds and falls; the rest guard
	// unlock, latch contents, the walks and the words sent to the flash
	a_unlock_needed: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(state_reg == ST_LOAD) |-> $past(unl_reg) == UNL_KEY2)
		else $error("load started without unlock");
	a_start_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_LOAD && ctrl_reg[BIT_LATCH_ONLY_BIT]) |=> !ctrl_reg[BIT_START])
		else $error("start bit not cleared after load");
	a_latch_only: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_LOAD && ctrl_reg[BIT_LATCH_ONLY_BIT]) |=> state_reg == ST_IDLE)
		else $error("latch-only load went on");
	a_commit_goes: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_LOAD && !ctrl_reg[BIT_LATCH_ONLY_BIT]) |=> state_reg == ST_PROGRAM)
		else $error("commit did not program");
	a_blank_after: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_BLANK) |=> latch_reg[$past(col_reg)] == BLANK_WORD)
		else $error("latch not blanked");
	a_load_word: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_LOAD) |=> latch_reg[$past(addr_low_reg[LATCH_W-1:0])] ==
		{$past(data_high_reg), $past(data_low_reg)})
		else $error("latch word wrong");
	a_row_steady: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_PROGRAM) |=> $stable(row_reg))
		else $error("row moved during program");
	a_no_cfg: assert property (@(posedge pclk) disable iff (!presetn)
		(unlocked) |-> !ctrl_reg[BIT_CONFIG_SPACE_SELECT] && ctrl_reg[BIT_WRITE_ENABLE_BIT])
		else $error("unlock accepted without enable");
	// start stays visible for the whole commit, so a poll never sees
	// completion while words are still going out
	a_commit_held: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_PROGRAM || state_reg == ST_BLANK) |-> ctrl_reg[BIT_START])
		else $error("start bit dropped during commit");
	// the end of the blank walk closes the commit in one step
	a_commit_done: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_BLANK && is_last(col_reg)) |=>
		(!ctrl_reg[BIT_START] && state_reg == ST_IDLE))
		else $error("commit did not finish");
	// start only rises from an accepted unlock
	a_start_unlock: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(ctrl_reg[BIT_START]) |-> $past(unlocked))
		else $error("start set without unlock");
	// a whole row of words went out before the blank walk ends
	a_word_total: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_BLANK && is_last(col_reg)) |->
		words_reg == (LATCH_W+1)'(LATCH_COUNT))
		else $error("commit word count wrong");
	// the program walk always begins at the first column
	a_col_start: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_LOAD) |=> col_reg == '0)
		else $error("walk did not start at column zero");
	// words reach the flash only out of the program walk
	a_we_program: assert property (@(posedge pclk) disable iff (!presetn)
		flash_we |-> $past(state_reg == ST_PROGRAM))
		else $error("flash strobe outside program walk");
	// every word of a commit goes to the captured row
	a_we_row: assert property (@(posedge pclk) disable iff (!presetn)
		flash_we |-> flash_row == row_reg)
		else $error("word sent to another row");
	// an idle sequencer never strobes the flash
	a_idle_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_IDLE) |=> !flash_we)
		else $error("flash strobe while idle");
	// after a commit no latch keeps a loaded word
	a_blank_all: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_IDLE && $past(state_reg) == ST_BLANK) |-> all_blank)
		else $error("latches not blank after commit");
	c_latch_load: cover property (@(posedge pclk) disable iff (!presetn)
		state_reg == ST_LOAD && ctrl_reg[BIT_LATCH_ONLY_BIT]);
	c_row_commit: cover property (@(posedge pclk) disable iff (!presetn)
		state_reg == ST_BLANK ##1 state_reg == ST_IDLE);
	c_abort: cover property (@(posedge pclk) disable iff (!presetn)
		unl_reg == UNL_KEY1 ##1 unl_reg == UNL_NONE);
	c_stalled_word: cover property (@(posedge pclk) disable iff (!presetn)
		state_reg == ST_PROGRAM && !flash_ready);
	c_start_refused: cover property (@(posedge pclk) disable iff (!presetn)
		wr && paddr == OFF_CTRL && pwdata[BIT_START] && !unlocked);
endmodule

// *** logic/flash_row_pkg.sv ***
// package: register map, field positions and constants of the flash row write sequencer
package flash_row_pkg;
	// register byte offsets on the apb bus
	localparam logic [7:0] OFF_ADDR_LOW  = 8'h00; // prog_addr_low
	localparam logic [7:0] OFF_ADDR_HIGH = 8'h04; // prog_addr_high
	localparam logic [7:0] OFF_DATA_LOW  = 8'h08; // prog_data_low
	localparam logic [7:0] OFF_DATA_HIGH = 8'h0C; // prog_data_high
	localparam logic [7:0] OFF_CTRL      = 8'h10; // flash_control_one
	localparam logic [7:0] OFF_KEY       = 8'h14; // flash_unlock_key_reg
	// flash_control_one bit positions
	localparam int BIT_START   = 1; // write-start, self clearing
	localparam int BIT_WRITE_ENABLE_BIT    = 2; // write_enable_bit
	localparam int BIT_LATCH_ONLY_BIT    = 5; // latch_only_bit
	localparam int BIT_CONFIG_SPACE_SELECT    = 6; // config_space_select
	// geometry
	localparam int LATCH_COUNT = 32;
	localparam int LATCH_W     = 5;
	localparam int ROW_W       = 10;
	localparam int WORD_W      = 14;
	localparam logic [13:0] BLANK_WORD = 14'h3FFF;
	// unlock keys, values arbitrary
	localparam logic [7:0] KEY_FIRST  = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'hAA;
	// reset values
	localparam logic [7:0] ADDR_HIGH_RST = 8'h80; // top bit reads as one
	localparam logic [7:0] CTRL_RST      = 8'h80;
	// sequencer states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_LOAD,
		ST_PROGRAM,
		ST_BLANK
	} seq_state_t;
	typedef enum logic [1:0] {
		UNL_NONE,
		UNL_KEY1,
		UNL_KEY2
	} unlock_state_t;
endpackage

// *** sim/test_flash_row_write_sequencer.sv ***
// self-checking bench of the flash row write sequencer
module test_flash_row_write_sequencer;
	timeunit 1ns;
	timeprecision 1ns;
	import flash_row_pkg::*;
	// ==========================================
	// signals
	logic        pclk = 1'b0;      // system clock
	logic        presetn = 1'b0;   // reset, low
	logic        psel = 1'b0;      // apb select
	logic        penable = 1'b0;   // apb access
	logic        pwrite = 1'b0;    // apb direction
	logic [7:0]  paddr = 8'h00;    // apb address
	logic [31:0] pwdata = 32'h0;   // apb write data
	logic [31:0] prdata;           // apb read data
	logic        pready;           // apb ready
	logic        pslverr;          // apb error
	logic        flash_we;         // program strobe
	logic [9:0]  flash_row;        // programmed row
	logic [4:0]  flash_col;        // programmed word
	logic [13:0] flash_wdata;      // programmed data
	logic [13:0] got [32];         // words seen per column
	logic [9:0]  row_seen;         // last row seen
	int          nwe = 0;          // strobes seen
	int          miscompares = 0;  // mismatches
	int          checks = 0;       // comparisons
	logic [31:0] rd;               // read result
	logic        er;               // read error
	logic        flash_ready = 1'b1; // flash accepts word, stalls every other cycle
	always #10 pclk = ~pclk;
	flash_row_write_sequencer i_flash_row_write_sequencer (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_we(flash_we),
		.flash_row(flash_row), .flash_col(flash_col), .flash_wdata(flash_wdata),
		.flash_ready(flash_ready));
	// the flash takes a word only on every other cycle
	always @(posedge pclk) flash_ready <= ~flash_ready;
	// records every word handed to the flash
	always @(posedge pclk) begin
		if (flash_we === 1'b1) begin
			got[flash_col] <= flash_wdata;
			row_seen <= flash_row;
			nwe <= nwe + 1;
		end
	end
	// ==========================================
	// shared tasks
	task automatic chk(input logic c, input string m);
		checks++;
		if (c !== 1'b1) begin
			miscompares++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// keys then start; waits for the start bit to drop when asked
	task automatic unlock(input logic [7:0] c, input bit poll);
		int n;
		apb(1, OFF_KEY, {24'h0, KEY_FIRST});
		apb(1, OFF_KEY, {24'h0, KEY_SECOND});
		apb(1, OFF_CTRL, {24'h0, c | 8'h02});
		n = 0;
		do begin
			apb(0, OFF_CTRL, 0);
			n++;
		end while (poll && rd[1] !== 1'b0 && n < 200);
		if (poll) chk(rd[1] === 1'b0, "start bit stuck");
	endtask
	task automatic load(input logic [4:0] col, input logic [13:0] w, input logic [7:0] c);
		apb(1, OFF_ADDR_LOW, {24'h0, 3'b111, col});
		apb(1, OFF_DATA_HIGH, {26'h0, w[13:8]});
		apb(1, OFF_DATA_LOW, {24'h0, w[7:0]});
		unlock(c, 1);
	endtask
	// compares one committed row with two expected words
	task automatic expect_row(input logic [4:0] ca, input logic [13:0] wa,
			input logic [4:0] cb, input logic [13:0] wb, input int base);
		chk(nwe == base + 32, "word count of commit");
		chk(row_seen === 10'h157, "row address");
		for (int c = 0; c < 32; c++) begin
			chk(got[c] === (c == ca ? wa : (c == cb ? wb : BLANK_WORD)), "latch word");
		end
	endtask
	// ==========================================
	// scenarios
	task automatic t_reset_and_map;
		apb(0, OFF_ADDR_HIGH, 0);
		chk(rd === 32'h80 && er === 1'b0, "address high reset");
		apb(0, OFF_CTRL, 0);
		chk(rd === 32'h80, "control reset");
		apb(0, 8'h3C, 0);
		chk(er === 1'b1, "unmapped access");
	endtask
	task automatic t_row_commit;
		apb(1, OFF_ADDR_HIGH, 32'h2A);
		apb(1, OFF_CTRL, 32'h24);
		load(5'd31, 14'h3ABC, 8'h24);
		chk(nwe == 0, "latch-only load programmed flash");
		load(5'd2, 14'h1234, 8'h04);
		expect_row(5'd31, 14'h3ABC, 5'd2, 14'h1234, 0);
	endtask
	task automatic t_broken_unlock;
		apb(1, OFF_ADDR_LOW, 32'hE7);
		apb(1, OFF_DATA_LOW, 32'h11);
		apb(1, OFF_KEY, {24'h0, KEY_FIRST});
		apb(0, OFF_DATA_LOW, 0);
		apb(1, OFF_KEY, {24'h0, KEY_SECOND});
		apb(1, OFF_CTRL, 32'h26);
		apb(1, OFF_CTRL, 32'h20);
		unlock(8'h20, 0);
		repeat (100) @(posedge pclk);
		chk(nwe == 32, "disabled or broken unlock acted");
		apb(1, OFF_CTRL, 32'h04);
		load(5'd9, 14'h0F0F, 8'h04);
		expect_row(5'd9, 14'h0F0F, 5'd9, 14'h0F0F, 32);
	endtask
	// ==========================================
	// closing and main sequence
	task automatic summarize;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		#(20 * 30000);
		miscompares++;
		summarize();
	end
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_reset_and_map();
		t_row_commit();
		t_broken_unlock();
		summarize();
	end
endmodule
